// ### bench/tb_top.sv
// Self-checking bench for the stopwatch capture read-out block
`timescale 1ns/1ps
module tb_top;
  import swcr_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [3:0]  data;
  } swcr_row_s;
  // Register rows: a write row stores data, a read row expects data
  localparam swcr_row_s ROWS [9] = '{
    '{1'b0, 16'hff7a, 4'h0}, '{1'b0, 16'hff7b, 4'h0},
    '{1'b0, 16'hff7c, 4'h0}, '{1'b0, 16'hffe6, 4'h0},
    '{1'b0, 16'hfff6, 4'h0}, '{1'b0, 16'hff79, 4'h0},
    '{1'b1, 16'hffe6, 4'h3}, '{1'b0, 16'hffe6, 4'h3},
    '{1'b0, 16'h0010, 4'h0}};
  logic              ref_clk_i   = 1'b0;
  logic              rst_n_i     = 1'b1;
  logic [ADDR_W-1:0] addr_i      = 16'h0000;
  logic [DATA_W-1:0] wdata_i     = 4'h0;
  logic              wr_i        = 1'b0;
  logic              rd_i        = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic [3:0]        live_ms     = 4'h0;
  logic [3:0]        live_hund   = 4'h0;
  logic [3:0]        live_tenth  = 4'h0;
  logic              lap_capture = 1'b0;
  logic [3:0]        evt         = 4'h0;
  logic              irq_o;
  logic              hold_o;
  int                error_cnt   = 0;
  int                comparisons = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  swcr_readout i_dut (
    .ref_clk_i     (ref_clk_i),
    .rst_n_i       (rst_n_i),
    .addr_i        (addr_i),
    .wdata_i       (wdata_i),
    .wr_i          (wr_i),
    .rd_i          (rd_i),
    .rdata_o       (rdata_o),
    .live_ms_i     (live_ms),
    .live_hund_i   (live_hund),
    .live_tenth_i  (live_tenth),
    .lap_capture_i (lap_capture),
    .run_key_evt_i (evt[BIT_RUN_KEY]),
    .lap_key_evt_i (evt[BIT_LAP_KEY]),
    .one_hz_evt_i  (evt[BIT_ONE_HZ]),
    .ten_hz_evt_i  (evt[BIT_TEN_HZ]),
    .irq_o         (irq_o),
    .hold_o        (hold_o)
  );

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [3:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : rd

  task automatic pulse(input logic [3:0] e, input logic cap);
    @(posedge ref_clk_i);
    evt         <= e;
    lap_capture <= cap;
    @(posedge ref_clk_i);
    evt         <= 4'h0;
    lap_capture <= 1'b0;
    #1;
  endtask : pulse

  task automatic close_out;
    $display("Counts: comparisons=%0d mismatches=%0d", comparisons,
             error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end

  initial
  begin
    // A real falling edge at time zero resets the synchroniser at once
    rst_n_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    foreach (ROWS[i])
    begin
      if (ROWS[i].wr)
        wr(ROWS[i].addr, ROWS[i].data);
      else
        rd(ROWS[i].addr, ROWS[i].data);
    end
    $display("test table done");
    @(posedge ref_clk_i);
    {live_ms, live_hund, live_tenth} <= 12'h123;
    rd(16'hff7a, 4'h1);
    chk({3'h0, hold_o}, 4'h1);
    {live_ms, live_hund, live_tenth} <= 12'h789;
    wr(16'hff7b, 4'h5);
    rd(16'hff7b, 4'h2);
    rd(16'hff7c, 4'h3);
    chk({3'h0, hold_o}, 4'h0);
    rd(16'hff79, 4'h0);
    rd(16'hff7a, 4'h7);
    @(posedge ref_clk_i);
    #1 chk(rdata_o, 4'h0);
    $display("test hold done");
    {live_ms, live_hund, live_tenth} <= 12'h456;
    pulse(4'h0, 1'b1);
    rd(16'hff7a, 4'h4);
    rd(16'hff7b, 4'h5);
    rd(16'hff7c, 4'h6);
    chk({3'h0, hold_o}, 4'h1);
    rd(16'hff79, 4'h4);
    rd(16'hff7c, 4'h6);
    chk({3'h0, hold_o}, 4'h0);
    rd(16'hff79, 4'h0);
    $display("test renewal done");
    for (int b = 0; b < 4; b++)
    begin
      pulse(4'h1 << b, 1'b0);
      chk({3'h0, irq_o}, {3'h0, b < 2});
      rd(16'hfff6, 4'h1 << b);
      wr(16'hfff6, 4'h0);
      rd(16'hfff6, 4'h1 << b);
      wr(16'hfff6, 4'h1 << b);
      rd(16'hfff6, 4'h0);
      chk({3'h0, irq_o}, 4'h0);
    end
    // Event and clearing write in one cycle: the event must win
    @(posedge ref_clk_i);
    addr_i  <= 16'hfff6;
    wdata_i <= 4'h1;
    wr_i    <= 1'b1;
    evt     <= 4'h1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
    evt     <= 4'h0;
    rd(16'hfff6, 4'h1);
    wr(16'hfff6, 4'h1);
    rd(16'hfff6, 4'h0);
    wr(16'hffe6, 4'h0);
    pulse(4'h2, 1'b0);
    chk({3'h0, irq_o}, 4'h0);
    wr(16'hffe6, 4'h2);
    #1 chk({3'h0, irq_o}, 4'h1);
    $display("test interrupts done");
    // Reset in mid-run must drop flags, enables and the held digits
    rd(16'hff7a, 4'h4);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    #1 chk({2'h0, irq_o, hold_o}, 4'h0);
    repeat (2) @(posedge ref_clk_i);
    {live_ms, live_hund, live_tenth} <= 12'h000;
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rd(16'hfff6, 4'h0);
    rd(16'hffe6, 4'h0);
    rd(16'hff7a, 4'h0);
    $display("test reset done");
    close_out();
  end
endmodule : tb_top

// ### verilog/swcr_pkg.sv
// Constants for the stopwatch capture read-out block
package swcr_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 4;
  localparam logic [15:0] OFS_MS_DIGIT    = 16'hff7a;
  localparam logic [15:0] OFS_HUND_DIGIT  = 16'hff7b;
  localparam logic [15:0] OFS_TENTH_DIGIT = 16'hff7c;
  localparam logic [15:0] OFS_CAPT_STATUS = 16'hff79;
  localparam logic [15:0] OFS_IRQ_ENABLE  = 16'hffe6;
  localparam logic [15:0] OFS_IRQ_FLAGS   = 16'hfff6;
  // Bit positions shared by enable and flag registers, then the renewed bit of the capture status
  localparam int          BIT_TEN_HZ      = 0;
  localparam int          BIT_ONE_HZ      = 1;
  localparam int          BIT_LAP_KEY     = 2;
  localparam int          BIT_RUN_KEY     = 3;
  localparam int          BIT_RENEWED     = 2;
  localparam logic [3:0]  RST_DIGIT       = 4'h0;
  localparam logic [3:0]  RST_ENABLE      = 4'h0;
  localparam logic [3:0]  RST_FLAGS       = 4'h0;
  typedef enum logic [1:0] {
    SWCR_TRACK,
    SWCR_HOLD
  } swcr_state_e;
endpackage : swcr_pkg

// ### verilog/swcr_readout.sv
// Stopwatch capture buffer read-out with interrupt flags and masks
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
//
// Contract
// - 1 Hz and 10 Hz enable bits pass interrupt when 1; reset 0.
// - RUN key flag reads 1 after a RUN key event; reset 0.
// - LAP key flag lives in the same flag register as RUN.
// - 1 Hz flag records the 1 Hz event in the shared register.
// - Writing 1 clears a flag; writing 0 leaves it unchanged.
// - Millisecond digit readable as 4-bit BCD register.
// - Reading the millisecond digit puts the capture buffer on hold.
// - Hundredths digit readable as its own 4-bit register.
// - Tenths digit readable as its own 4-bit register.
// - Writes to digit registers are ignored.
// - Reset clears all captured digits to zero.
// - Flags set on their event even when masked.
// - Renewal during hold: tenths read sets renewed flag, keeps hold.
module swcr_readout
  import swcr_pkg::*;
(
  // Clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_n_i,
  // Register port
  input  wire logic [swcr_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [swcr_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [swcr_pkg::DATA_W-1:0] rdata_o,
  // Live counter digits and capture strobe
  input  wire logic [3:0]                 live_ms_i,
  input  wire logic [3:0]                 live_hund_i,
  input  wire logic [3:0]                 live_tenth_i,
  input  wire logic                       lap_capture_i,
  // Interrupt events, one-cycle pulses
  input  wire logic                       run_key_evt_i,
  input  wire logic                       lap_key_evt_i,
  input  wire logic                       one_hz_evt_i,
  input  wire logic                       ten_hz_evt_i,
  // Interrupt output and hold status
  output logic                            irq_o,
  output logic                            hold_o
);
  import swcr_pkg::*;

  logic                rst_sync1_reg;
  logic                rst_sync2_reg;
  logic                rst_n;
  logic [3:0]          ms_digit_reg;
  logic [3:0]          hundredths_digit_reg;
  logic [3:0]          tenths_digit_reg;
  logic [3:0]          irq_enable_reg;
  logic [3:0]          irq_flags_reg;
  logic [3:0]          irq_flags_next;
  logic [3:0]          evt_vec;
  logic                capture_renewed_flag_reg;
  logic                renew_pending_reg;
  swcr_state_e         state_reg;
  logic                rd_ms;
  logic                rd_tenth;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Release reset through two flops so removal is clock aligned
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rst_n = rst_sync2_reg;

  assign rd_ms    = rd_i && hit(addr_i, OFS_MS_DIGIT);
  assign rd_tenth = rd_i && hit(addr_i, OFS_TENTH_DIGIT);
  assign hold_o   = (state_reg == SWCR_HOLD);

  // Hold state machine
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= SWCR_TRACK;
    end
    else
    begin
      case (state_reg)
        SWCR_TRACK:
        begin
          if (rd_ms)
          begin
            state_reg <= SWCR_HOLD;
          end
        end
        SWCR_HOLD:
        begin
          if (rd_tenth && !renew_pending_reg)
          begin
            state_reg <= SWCR_TRACK;
          end
        end
        default:
        begin
          state_reg <= SWCR_TRACK;
        end
      endcase
    end
  end

  // Capture digits: follow live count when tracking, LAP renews in hold.
  // The read that starts the hold sees the value already in the buffer.
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ms_digit_reg         <= RST_DIGIT;
      hundredths_digit_reg <= RST_DIGIT;
      tenths_digit_reg     <= RST_DIGIT;
    end
    else if ((!hold_o && !rd_ms) || (hold_o && lap_capture_i))
    begin
      ms_digit_reg         <= live_ms_i;
      hundredths_digit_reg <= live_hund_i;
      tenths_digit_reg     <= live_tenth_i;
    end
  end

  // Renewal tracking
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      renew_pending_reg        <= 1'b0;
      capture_renewed_flag_reg <= 1'b0;
    end
    else
    begin
      if (rd_tenth && hold_o)
      begin
        capture_renewed_flag_reg <= renew_pending_reg;
        renew_pending_reg        <= lap_capture_i;
      end
      else if (hold_o && lap_capture_i)
      begin
        renew_pending_reg <= 1'b1;
      end
    end
  end

  // Interrupt enables
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_enable_reg <= RST_ENABLE;
    end
    else if (wr_i && hit(addr_i, OFS_IRQ_ENABLE))
    begin
      irq_enable_reg <= wdata_i;
    end
  end

  assign evt_vec[BIT_RUN_KEY] = run_key_evt_i;
  assign evt_vec[BIT_LAP_KEY] = lap_key_evt_i;
  assign evt_vec[BIT_ONE_HZ]  = one_hz_evt_i;
  assign evt_vec[BIT_TEN_HZ]  = ten_hz_evt_i;

  // Flags: set beats clear so no event is lost
  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_flag
      always_comb
      begin
        irq_flags_next[i] = irq_flags_reg[i];
        if (wr_i && hit(addr_i, OFS_IRQ_FLAGS) && wdata_i[i])
        begin
          irq_flags_next[i] = 1'b0;
        end
        if (evt_vec[i])
        begin
          irq_flags_next[i] = 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_flags_reg <= RST_FLAGS;
    end
    else
    begin
      irq_flags_reg <= irq_flags_next;
    end
  end

  assign irq_o = |(irq_flags_reg & irq_enable_reg);

  // Read data, valid the cycle after the strobe only
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_o <= 4'h0;
    end
    else if (!rd_i)
    begin
      rdata_o <= 4'h0;
    end
    else
    begin
      case (addr_i)
        OFS_MS_DIGIT:    rdata_o <= ms_digit_reg;
        OFS_HUND_DIGIT:  rdata_o <= hundredths_digit_reg;
        OFS_TENTH_DIGIT: rdata_o <= tenths_digit_reg;
        OFS_CAPT_STATUS:
          rdata_o <= {1'b0, capture_renewed_flag_reg, 2'b00};
        OFS_IRQ_ENABLE:  rdata_o <= irq_enable_reg;
        OFS_IRQ_FLAGS:   rdata_o <= irq_flags_reg;
        default:         rdata_o <= 4'h0;
      endcase
    end
  end

  sequence s_ms_read;
    rd_ms && !hold_o;
  endsequence

  a_hold_on_ms_read:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      s_ms_read |=> hold_o)
    else $error("hold not entered after ms read");

  a_digits_frozen:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (hold_o && !lap_capture_i) |=> $stable(ms_digit_reg))
    else $error("digit changed while held");

  a_release_hold:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (hold_o && rd_tenth && !renew_pending_reg) |=> !hold_o)
    else $error("hold not released");

  a_renew_keeps:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (hold_o && rd_tenth && renew_pending_reg)
        |=> hold_o && capture_renewed_flag_reg)
    else $error("renewal not flagged");

  a_flag_set_evt:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      one_hz_evt_i |=> irq_flags_reg[BIT_ONE_HZ])
    else $error("1 Hz flag not set");

  a_run_flag_set:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      run_key_evt_i |=> irq_flags_reg[BIT_RUN_KEY])
    else $error("run flag not set");

  a_flag_w1c:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (wr_i && hit(addr_i, OFS_IRQ_FLAGS) && wdata_i[BIT_TEN_HZ]
        && !ten_hz_evt_i) |=> !irq_flags_reg[BIT_TEN_HZ])
    else $error("10 Hz flag not cleared");

  a_flag_w0_keep:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (irq_flags_reg[BIT_LAP_KEY] && !(wr_i && wdata_i[BIT_LAP_KEY]))
        |=> irq_flags_reg[BIT_LAP_KEY])
    else $error("lap flag lost");

  a_irq_masking:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (one_hz_evt_i && irq_enable_reg[BIT_ONE_HZ]
        && !(wr_i && hit(addr_i, OFS_IRQ_ENABLE))) |=> irq_o)
    else $error("unmasked 1 Hz event gave no irq");

  a_ms_readback:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (rd_ms && hold_o) |=> rdata_o == $past(ms_digit_reg))
    else $error("ms digit readback wrong");

endmodule : swcr_readout
